// ===== ccp_mode_control.v
// Capture/compare channel with mode control register behind an APB slave
// Summary of operation
// - Mode 0000 disables the channel and clears its output, event flag and prescale counter; the value register is kept.
// - Mode 0001 is reserved and enables no capture, compare or PWM function.
// - Mode 0010 toggles the output pin and sets the event flag on every timer match.
// - Mode 0101 latches the timer into the value register on every rising pin edge.
// - Mode 0110 captures only on every fourth rising pin edge.
// - Mode 0111 captures only on every sixteenth rising pin edge.
// - Mode 1000 drives the output pin high and sets the event flag on a timer match.
// - Each capture copies the full 16-bit timer and sets the flag that software clears.
// - A new capture overwrites an unread earlier value.
// - The prescale counter clears when off, outside capture, or on reset, not on a switch.
// - Compare modes continuously compare the value register with the timer count.
`timescale 1ns/1ps
`include "ccp_mode_control_map.vh"
module ccp_mode_control #(
  parameter TIMER_WIDTH = 16
)(
  input  wire                   core_clk,
  input  wire                   arst_n,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [11:0]            paddr,
  input  wire [31:0]            pwdata,
  input  wire [3:0]             pstrb,
  output wire [31:0]            prdata,
  output wire                   pready,
  output wire                   pslverr,
  input  wire [TIMER_WIDTH-1:0] shared_timebase_count,
  input  wire                   channel_pin_in,
  output wire                   channel_pin_out,
  output wire                   channel_pin_oe,
  output wire                   irq
);

  reg                   rst_meta_q;
  reg                   rst_sync_q;
  wire                  rst_n;
  reg                   pin_meta_q;
  reg                   pin_sync_q;
  reg                   pin_prev_q;
  reg  [7:0]            ctrl_q;
  reg  [TIMER_WIDTH-1:0] value_q;
  reg                   flag_q;
  reg                   mask_q;
  reg  [3:0]            presc_q;
  reg                   out_q;
  reg                   match_prev_q;
  reg  [31:0]           rdata_q;
  wire [3:0]            mode;
  wire                  wr_en;
  wire                  rd_en;
  wire                  rise;
  wire                  fall;
  wire                  cap_mode;
  wire                  cmp_mode;
  wire                  match;
  wire                  match_evt;
  reg                   cap_evt;
  wire                  cmp_evt;
  wire                  mapped;
  wire                  wr_ctrl;
  wire                  wr_value;
  wire                  wr_mask;
  wire                  rd_status;

  function is_capture;
    input [3:0] m;
    begin
      is_capture = (m == `MODE_CAP_FALL) || (m == `MODE_CAP_RISE) ||
                   (m == `MODE_CAP_RISE4) || (m == `MODE_CAP_RISE16);
    end
  endfunction

  function is_compare;
    input [3:0] m;
    begin
      is_compare = (m == `MODE_CMP_TOGGLE) || (m == `MODE_CMP_SET);
    end
  endfunction

  // Reset release through two flops
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // Pin is asynchronous; edges are taken only after the second flop
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= channel_pin_in;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end
  assign rise = pin_sync_q & ~pin_prev_q;
  assign fall = ~pin_sync_q & pin_prev_q;

  assign mode     = ctrl_q[`MODE_MSB:`MODE_LSB];
  // reserved code
  // Only listed codes enable anything, so 0001 and others stay idle
  assign cap_mode = is_capture(mode);
  assign cmp_mode = is_compare(mode);

  assign wr_en  = psel & penable & pwrite;
  assign rd_en  = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == `CTRL_OFFSET) || (paddr == `VALUE_OFFSET) ||
                  (paddr == `STATUS_OFFSET) || (paddr == `MASK_OFFSET) ||
                  (paddr == `TIMEBASE_OFFSET);
  assign pslverr = psel & penable & ~mapped;
  assign wr_ctrl   = wr_en && (paddr == `CTRL_OFFSET);
  assign wr_value  = wr_en && (paddr == `VALUE_OFFSET);
  assign wr_mask   = wr_en && (paddr == `MASK_OFFSET);
  assign rd_status = rd_en && (paddr == `STATUS_OFFSET);

  // Capture event selection and prescale
  always @*
  begin
    cap_evt = 1'b0;
    case (mode)
      `MODE_CAP_FALL:   cap_evt = fall;
      `MODE_CAP_RISE:   cap_evt = rise;
      `MODE_CAP_RISE4:  cap_evt = rise & (presc_q[1:0] == `PRESCALE_4_LAST);
      `MODE_CAP_RISE16: cap_evt = rise & (presc_q == `PRESCALE_16_LAST);
      default:          cap_evt = 1'b0;
    endcase
  end

  // continuous compare
  // Edge of equality fires once even if the timer stalls on the value
  assign match     = (value_q == shared_timebase_count);
  assign match_evt = match & ~match_prev_q;
  assign cmp_evt   = cmp_mode & match_evt;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_q <= 4'h0;
    end
    else if (!cap_mode)
    begin
      presc_q <= 4'h0;
    end
    else if (rise)
    begin
      presc_q <= presc_q + 4'h1;
    end
  end

  // Control register; bits 7:6 are not stored and read as zero
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= `CTRL_RESET;
    end
    else if (wr_ctrl && pstrb[0])
    begin
      ctrl_q <= pwdata[7:0] & `CTRL_MASK;
    end
  end

  // Interrupt mask for the event flag
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_q <= 1'b0;
    end
    else if (wr_mask && pstrb[0])
    begin
      mask_q <= pwdata[`EVENT_BIT];
    end
  end

  // capture overwrites value
  // A capture beats a same-cycle software write so no event is lost
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      value_q <= {TIMER_WIDTH{1'b0}};
    end
    else if (cap_evt)
    begin
      value_q <= shared_timebase_count;
    end
    else if (wr_value)
    begin
      if (pstrb[0])
        value_q[7:0] <= pwdata[7:0];
      if (pstrb[1])
        value_q[TIMER_WIDTH-1:8] <= pwdata[TIMER_WIDTH-1:8];
    end
  end

  // Previous equality, for the rising edge of a match
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      match_prev_q <= 1'b0;
    end
    else
    begin
      match_prev_q <= match;
    end
  end

  // Compare output
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q <= 1'b0;
    end
    else if (mode == `MODE_OFF)
    begin
      out_q <= 1'b0;
    end
    else if (mode == `MODE_CMP_TOGGLE && cmp_evt)
    begin
      out_q <= ~out_q;
    end
    else if (mode == `MODE_CMP_SET && cmp_evt)
    begin
      out_q <= 1'b1;
    end
  end

  // Event flag: set wins over the read-clear; mode off also clears it
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_q <= 1'b0;
    end
    // flag set on capture or match
    else if (cap_evt || cmp_evt)
    begin
      flag_q <= 1'b1;
    end
    else if (rd_status)
    begin
      flag_q <= 1'b0;
    end
    else if (mode == `MODE_OFF)
    begin
      flag_q <= 1'b0;
    end
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `CTRL_OFFSET:     rdata_q <= {24'h00_0000, ctrl_q};
        `VALUE_OFFSET:    rdata_q <= {16'h0000, value_q};
        `STATUS_OFFSET:   rdata_q <= {31'h0000_0000, flag_q};
        `MASK_OFFSET:     rdata_q <= {31'h0000_0000, mask_q};
        `TIMEBASE_OFFSET: rdata_q <= {16'h0000, shared_timebase_count};
        default:          rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata          = rdata_q;
  assign irq             = flag_q & mask_q;
  // Pin is driven only in compare modes; capture leaves it an input
  assign channel_pin_oe  = cmp_mode;
  assign channel_pin_out = out_q;

endmodule

// ===== ccp_mode_control_map.vh
// Register offsets, fields, reset values and mode codes for the channel
`ifndef CCP_MODE_CONTROL_MAP_VH
`define CCP_MODE_CONTROL_MAP_VH
`define CTRL_OFFSET        12'h000
`define VALUE_OFFSET       12'h004
`define STATUS_OFFSET      12'h008
`define MASK_OFFSET        12'h00c
`define TIMEBASE_OFFSET    12'h010
`define CTRL_RESET         8'h00
`define CTRL_MASK          8'h3f
`define MODE_LSB           0
`define MODE_MSB           3
`define DUTY_LSB           4
`define DUTY_MSB           5
`define MODE_OFF           4'h0
`define MODE_RSVD          4'h1
`define MODE_CMP_TOGGLE    4'h2
`define MODE_CAP_FALL      4'h4
`define MODE_CAP_RISE      4'h5
`define MODE_CAP_RISE4     4'h6
`define MODE_CAP_RISE16    4'h7
`define MODE_CMP_SET       4'h8
`define PRESCALE_4_LAST    4'h3
`define PRESCALE_16_LAST   4'hf
`define EVENT_BIT          0
`endif

// ===== ccp_far_side.sv
// Far side model: shared timebase and the external event source
`timescale 1ns/1ps
module ccp_far_side (
  input  wire        core_clk,
  output reg  [15:0] shared_timebase_count,
  output reg         pin_drv
);
  initial
  begin
    shared_timebase_count = 16'h0000;
    pin_drv = 1'b0;
  end
  // Timer held still so each capture has one exact expected value
  task load(input [15:0] v);
    @(posedge core_clk) shared_timebase_count <= v;
  endtask
  // Wide pulse so the two-flop synchroniser never misses it
  task pulse;
    @(posedge core_clk) pin_drv <= 1'b1;
    repeat (4) @(posedge core_clk);
    pin_drv <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// ===== ccp_mode_control_asserts.sv
// Port checks for the capture/compare channel
`timescale 1ns/1ps
`include "ccp_mode_control_map.vh"
module ccp_mode_control_asserts #(
  parameter TIMER_WIDTH = 16
)(
  input wire                   core_clk,
  input wire                   arst_n,
  input wire                   psel,
  input wire                   penable,
  input wire                   pwrite,
  input wire [11:0]            paddr,
  input wire [31:0]            pwdata,
  input wire [3:0]             pstrb,
  input wire [TIMER_WIDTH-1:0] shared_timebase_count,
  input wire                   channel_pin_in,
  input wire                   channel_pin_out,
  input wire                   channel_pin_oe,
  input wire                   irq
);
  reg  [3:0]             mode_q;
  reg  [3:0]             rise_q;
  reg                    mask_q;
  reg  [TIMER_WIDTH-1:0] val_q;
  wire                   wr = psel && penable && pwrite;
  wire                   hit = shared_timebase_count == val_q;
  // Shadow only tracks writes; captured values are not mirrored
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_q <= 4'h0;
      mask_q <= 1'b0;
      val_q <= '0;
      rise_q <= 4'h0;
    end
    else
    begin
      if (wr && paddr == `CTRL_OFFSET && pstrb[0])
        mode_q <= pwdata[3:0];
      if (wr && paddr == `MASK_OFFSET && pstrb[0])
        mask_q <= pwdata[0];
      if (wr && paddr == `VALUE_OFFSET && pstrb[0])
        val_q[7:0] <= pwdata[7:0];
      if (wr && paddr == `VALUE_OFFSET && pstrb[1])
        val_q[TIMER_WIDTH-1:8] <= pwdata[TIMER_WIDTH-1:8];
      if (mode_q[3:2] != 2'b01)
        rise_q <= 4'h0;
      else if ($rose(channel_pin_in))
        rise_q <= rise_q + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  off_quiet_a: assert property (mode_q == 4'h0 && $past(mode_q) == 4'h0
    |-> !channel_pin_out && !irq)
    else $error("output or irq active while off");
  oe_mode_a: assert property (channel_pin_oe == (mode_q == 4'h2 || mode_q == 4'h8))
    else $error("output enable wrong for mode");
  toggle_match_a: assert property ($rose(hit) && mode_q == 4'h2
    |=> channel_pin_out != $past(channel_pin_out))
    else $error("no toggle on match");
  set_match_a: assert property ($rose(hit) && mode_q == 4'h8 |=> channel_pin_out)
    else $error("no set on match");
  cap_rise_a: assert property (mode_q == 4'h5 && mask_q && $rose(channel_pin_in)
    |-> ##[1:4] irq)
    else $error("no event after rising edge");
  cap_fall_a: assert property (mode_q == 4'h4 && mask_q && $fell(channel_pin_in)
    |-> ##[1:4] irq)
    else $error("no event after falling edge");
  pre_skip_a: assert property (mode_q == 4'h6 && !irq && $rose(channel_pin_in)
    && rise_q[1:0] != 2'h3 |=> !irq [*4])
    else $error("capture before fourth edge");
  pre_hit_a: assert property (mode_q == 4'h7 && mask_q && $rose(channel_pin_in)
    && rise_q == 4'hf |-> ##[1:4] irq)
    else $error("no capture on sixteenth edge");
  cover property (mode_q == 4'h7 && rise_q == 4'hf && $rose(channel_pin_in));
  cover property ($rose(hit) && mode_q == 4'h2);
  cover property ($rose(irq));
endmodule
bind ccp_mode_control ccp_mode_control_asserts #(.TIMER_WIDTH(TIMER_WIDTH)) u_chk (
  .core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .shared_timebase_count,
  .channel_pin_in, .channel_pin_out, .channel_pin_oe, .irq);

// ===== ccp_mode_control_tb_top.sv
// Register-level bench for the capture/compare channel
`timescale 1ns/1ps
`include "ccp_mode_control_map.vh"
module ccp_mode_control_tb_top;
  reg         core_clk;
  reg         arst_n;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata;
  reg  [31:0] q;
  reg  [3:0]  strb;
  reg         err;
  wire [31:0] prdata;
  wire        slverr;
  wire        pready;
  wire [15:0] tmr;
  wire        drv;
  wire        pin_out;
  wire        pin_oe;
  wire        irq;
  wire        pin = pin_oe ? pin_out : drv;
  integer     num_errors;
  integer     num_checks;
  integer     i;
  integer     p;
  ccp_mode_control dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
    .pready(pready), .pslverr(slverr), .shared_timebase_count(tmr), .channel_pin_in(pin),
    .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .irq(irq));
  ccp_far_side far (.core_clk(core_clk), .shared_timebase_count(tmr), .pin_drv(drv));
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task chk(input string nm, input [31:0] e, input [31:0] s);
    num_checks = num_checks + 1;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      num_errors = num_errors + 1;
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    err = slverr;
    {psel, penable} <= 2'b00;
  endtask
  task rd(input [11:0] a, input [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task look(input [31:0] eo, input [31:0] ei);
    repeat (3) @(negedge core_clk);
    chk("pin_out", eo, pin_out);
    chk("irq", ei, irq);
  endtask
  task conclude;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    strb = 4'hf;
    num_errors = 0;
    num_checks = 0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(`CTRL_OFFSET, 32'h0, "ctrl reset");
    apb(1'b1, `CTRL_OFFSET, 32'hff);
    rd(`CTRL_OFFSET, 32'h3f, "ctrl bits");
    chk("pslverr mapped", 0, err);
    rd(12'h100, 32'h0, "unmapped");
    chk("pslverr unmapped", 1, err);
    apb(1'b1, `MASK_OFFSET, 32'h1);
    apb(1'b1, `CTRL_OFFSET, `MODE_CAP_RISE);
    far.load(16'h1234);
    far.pulse;
    far.load(16'hbeef);
    far.pulse;
    rd(`VALUE_OFFSET, 32'hbeef, "value");
    look(0, 1);
    rd(`STATUS_OFFSET, 32'h1, "flag");
    look(0, 0);
    apb(1'b1, `CTRL_OFFSET, `MODE_CAP_FALL);
    far.load(16'h0a5a);
    far.pulse;
    rd(`VALUE_OFFSET, 32'h0a5a, "fall value");
    // Off between prescalers so the edge count restarts
    for (p = 4; p <= 16; p = p + 12)
    begin
      apb(1'b1, `CTRL_OFFSET, `MODE_OFF);
      apb(1'b1, `CTRL_OFFSET, p == 4 ? `MODE_CAP_RISE4 : `MODE_CAP_RISE16);
      for (i = 1; i <= p; i = i + 1)
      begin
        far.load(i[15:0]);
        far.pulse;
        if (i == p - 1)
          rd(`STATUS_OFFSET, 32'h0, "early flag");
      end
      rd(`VALUE_OFFSET, p, "prescaled value");
    end
    apb(1'b1, `CTRL_OFFSET, `MODE_OFF);
    apb(1'b1, `VALUE_OFFSET, 32'h0100);
    strb <= 4'h2;
    apb(1'b1, `VALUE_OFFSET, 32'h55aa);
    strb <= 4'h1;
    apb(1'b1, `VALUE_OFFSET, 32'h0077);
    strb <= 4'hf;
    rd(`VALUE_OFFSET, 32'h5577, "lane value");
    apb(1'b1, `VALUE_OFFSET, 32'h0100);
    far.load(16'h0000);
    apb(1'b1, `CTRL_OFFSET, `MODE_CMP_TOGGLE);
    far.load(16'h0100);
    look(1, 1);
    chk("pin_oe", 1, pin_oe);
    rd(`TIMEBASE_OFFSET, 32'h0100, "timebase");
    far.load(16'h0000);
    far.load(16'h0100);
    look(0, 1);
    apb(1'b1, `CTRL_OFFSET, `MODE_OFF);
    look(0, 0);
    apb(1'b1, `CTRL_OFFSET, `MODE_CMP_SET);
    far.load(16'h0000);
    far.load(16'h0100);
    look(1, 1);
    apb(1'b1, `CTRL_OFFSET, `MODE_OFF);
    apb(1'b1, `CTRL_OFFSET, `MODE_RSVD);
    far.pulse;
    look(0, 0);
    chk("pin_oe", 0, pin_oe);
    conclude;
  end
  initial
  begin
    #2000000;
    num_errors = num_errors + 1;
    conclude;
  end
endmodule
